// ==== include/power_control_defs.vh ====
`ifndef POWER_CONTROL_DEFS_VH
`define POWER_CONTROL_DEFS_VH

// Registers are reached by index; the byte address is four times the index.
`define IDX_LEVEL_POWER_CONTROL 8'h40
`define IDX_LATCHED_POWER_CONTROL 8'h41
`define ADDR_LEVEL_POWER_CONTROL 10'h100
`define ADDR_LATCHED_POWER_CONTROL 10'h104
`define ADDR_WIDTH 10

// Field positions in the level register.
`define LEVEL_CTL_BIT 0
`define LEVEL_STATE_BIT 1

// Reset values.
`define LEVEL_CTL_RESET 1'b0
`define LATCHED_RESET 8'h00

// AXI responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== verilog/power_control_latch.v ====
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "power_control_defs.vh"

// What this block does
// - Eight programmable latched power-control output lines.
// - During reset lines are inputs; levels captured on first clock after release.
// - Latch-level output low during reset.
// - Latched_power_control read returns captured/programmed value.
// - Latched_power_control write drives power-control lines.
// - Level output follows level_power_control bit D0.
// - Level_power_control bit D1 reports level output.
module power_control_latch (
	input wire clock,
	input wire sys_rst,
	input wire [`ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`ADDR_WIDTH-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] power_ctl_lines_in,
	output reg [7:0] power_ctl_lines_out,
	output reg [7:0] power_ctl_lines_oe_n,
	output reg latch_level_ctl
);

	reg [7:0] latched_value;
	reg level_ctl;
	reg capture_pending;
	reg aw_held;
	reg w_held;
	reg [`ADDR_WIDTH-1:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire do_write;
	wire do_read;
	localparam [`ADDR_WIDTH-1:0] lat_addr = `ADDR_LATCHED_POWER_CONTROL;
	localparam [`ADDR_WIDTH-1:0] lvl_addr = `ADDR_LEVEL_POWER_CONTROL;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign do_read = s_axi_arvalid && !s_axi_rvalid;

	// Lines float as inputs through reset; the first clock after release snapshots the
	// strapped defaults, since an async reset may only load constants.
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			capture_pending <= 1'b1;
			latched_value <= `LATCHED_RESET;
			level_ctl <= `LEVEL_CTL_RESET;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= {`ADDR_WIDTH{1'b0}};
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			capture_pending <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (capture_pending) begin
				latched_value <= power_ctl_lines_in;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (aw_addr[`ADDR_WIDTH-1:2] == lat_addr[`ADDR_WIDTH-1:2]) begin
					if (w_strb[0] && !capture_pending)
						latched_value <= w_data[7:0];
				end else if (aw_addr[`ADDR_WIDTH-1:2] == lvl_addr[`ADDR_WIDTH-1:2]) begin
					if (w_strb[0])
						level_ctl <= w_data[`LEVEL_CTL_BIT];
				end else begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (do_read) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			if (s_axi_araddr[`ADDR_WIDTH-1:2] == lat_addr[`ADDR_WIDTH-1:2]) begin
				s_axi_rdata <= {24'h000000, latched_value};
			end else if (s_axi_araddr[`ADDR_WIDTH-1:2] == lvl_addr[`ADDR_WIDTH-1:2]) begin
				s_axi_rdata <= {30'h00000000, latch_level_ctl, level_ctl};
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// The external latch holds while the level output is high and is transparent while it is low, so software
	// that has set D0 must load the value first and clear D0 afterwards to pass it through.
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			power_ctl_lines_out <= 8'h00;
			power_ctl_lines_oe_n <= 8'hff;
			latch_level_ctl <= 1'b0;
		end else begin
			power_ctl_lines_out <= latched_value;
			power_ctl_lines_oe_n <= capture_pending ? 8'hff : 8'h00;
			latch_level_ctl <= level_ctl;
		end
	end

endmodule // power_control_latch
`default_nettype wire

// ==== test/power_latch_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module ext_power_latch(input wire logic [7:0] d,n,input wire logic g,output logic [7:0] p,q);
	// Released pins fall to their straps, never to a stale drive.
	assign p=d&~n|8'h96&n;
	always_latch if(!g) q<=p;
endmodule // ext_power_latch
`default_nettype wire

// ==== test/power_control_latch_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcl_check(input wire clock,sys_rst,s_axi_rvalid,s_axi_bvalid,latch_level_ctl,
	input wire [9:0] s_axi_araddr,input wire [31:0] s_axi_rdata,
	input wire [7:0] power_ctl_lines_out,power_ctl_lines_oe_n);
	wire [7:0] o=power_ctl_lines_out,n=power_ctl_lines_oe_n;
	wire l=latch_level_ctl,b=s_axi_bvalid;
	default clocking @(posedge clock);endclocking
	default disable iff(sys_rst);
	a_rst_oe:assert property($fell(sys_rst)|->n==8'hff)else $error("oe");
	a_rst_lv:assert property($fell(sys_rst)|->!l)else $error("lv");
	a_drive:assert property(!$past(sys_rst)&&!$past(sys_rst,2)|->n==8'h00)else $error("drive");
	a_out_why:assert property($changed(o)&&$past(n)==8'h00|->$past(b))else $error("out");
	a_lv_why:assert property($changed(l)|->$past(b))else $error("level");
	a_rd_lat:assert property($rose(s_axi_rvalid)&&s_axi_araddr==10'h104
		|->s_axi_rdata[7:0]==o)else $error("rd");
	a_rd_lv:assert property($rose(s_axi_rvalid)&&s_axi_araddr==10'h100
		|->s_axi_rdata[1]==l)else $error("st");
endmodule // pcl_check
bind power_control_latch pcl_check chk_u(.*);
`default_nettype wire

// ==== test/power_control_latch_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module power_control_latch_test;
	logic clock=0,sys_rst=1,s_axi_awvalid=0,s_axi_wvalid=0,s_axi_bready=0,s_axi_arvalid=0;
	logic s_axi_rready=0,s_axi_awready,s_axi_wready,s_axi_bvalid,s_axi_arready,s_axi_rvalid;
	logic latch_level_ctl;
	logic [9:0] s_axi_awaddr=0,s_axi_araddr=0;
	logic [31:0] s_axi_wdata=0,s_axi_rdata,q;
	logic [3:0] s_axi_wstrb=4'hf;
	logic [1:0] s_axi_bresp,s_axi_rresp;
	logic [7:0] power_ctl_lines_in,power_ctl_lines_out,power_ctl_lines_oe_n,held;
	logic [27:0] rows[5]='{28'h4116968,28'h4129694,28'h400040c,28'h4000000,28'h421dc02};
	int miscompares,cmp_count;
	power_control_latch dut_u(.*);
	ext_power_latch part_u(.d(power_ctl_lines_out),.n(power_ctl_lines_oe_n),.g(latch_level_ctl),
		.p(power_ctl_lines_in),.q(held));
	always #5 clock=~clock;
	task chk(input logic [31:0] s,x);
		cmp_count++;
		if(s!==x)begin miscompares++;$display("ERROR %0t %h %h",$time,s,x);end
	endtask
	task acc(input logic w,input logic [9:0] a,input logic [7:0] d);
		@(posedge clock);
		{s_axi_awaddr,s_axi_araddr,s_axi_wdata}<={a,a,24'h0,d};
		{s_axi_awvalid,s_axi_wvalid,s_axi_bready,s_axi_arvalid,s_axi_rready}<={w,w,w,!w,!w};
		do begin
			@(posedge clock);
			s_axi_awvalid<=s_axi_awvalid&!s_axi_awready;
			s_axi_wvalid<=s_axi_wvalid&!s_axi_wready;
			s_axi_arvalid<=s_axi_arvalid&!s_axi_arready;
		end while(!s_axi_bvalid&&!s_axi_rvalid);
		q=w?{30'h0,s_axi_bresp}:s_axi_rdata;
		{s_axi_bready,s_axi_rready}<=2'h0;
	endtask
	task results;
		$display("%0d compares %0d miscompares",cmp_count,miscompares);
		if(miscompares==0&&cmp_count>0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat(12) @(posedge clock);
		sys_rst<=0;
		acc(0,10'h104,0);
		chk(q,8'h96);
		foreach(rows[i]) begin
			acc(1,rows[i][27:18],rows[i][17:10]);
			chk(q,rows[i][1:0]);
			acc(0,rows[i][27:18],0);
			chk(q,rows[i][9:2]);
			chk(s_axi_rresp,rows[i][1:0]);
			$display("row %0d done",i);
		end
		// Closing the latch first proves a new value cannot leak through.
		acc(1,10'h100,1);
		acc(1,10'h104,8'h3c);
		@(posedge clock);
		chk(held,8'ha5);
		acc(1,10'h100,0);
		@(posedge clock);
		chk(held,8'h3c);
		$display("latch done");
		results;
	end
	initial begin #100us;miscompares++;results;end
endmodule // power_control_latch_test
`default_nettype wire
